// [common/sbpu_defines.svh]
`ifndef SBPU_DEFINES_SVH
`define SBPU_DEFINES_SVH

// Command header decode.
`define SBPU_HDR_TYPE 3'h3
`define SBPU_HDR_SUBTYPE 2'h0
`define SBPU_HDR_OPCODE 3'h1
`define SBPU_HDR_SUBOP 8'h01
`define SBPU_HDR_TYPE_HI 31
`define SBPU_HDR_TYPE_LO 29
`define SBPU_HDR_SUB_HI 28
`define SBPU_HDR_SUB_LO 27
`define SBPU_HDR_OP_HI 26
`define SBPU_HDR_OP_LO 24
`define SBPU_HDR_SOP_HI 23
`define SBPU_HDR_SOP_LO 16
`define SBPU_HDR_LEN_HI 7
`define SBPU_HDR_LEN_LO 0

// Dword positions inside the command body.
`define SBPU_DW_GENERAL 2'h1
`define SBPU_DW_SURFACE 2'h2

// Body field layout, shared by dword 1 and dword 2.
`define SBPU_BASE_HI 31
`define SBPU_BASE_LO 12
`define SBPU_MOCS_HI 11
`define SBPU_MOCS_LO 8
`define SBPU_SDP_HI 7
`define SBPU_SDP_LO 4
`define SBPU_FORCE_WT_BIT 3
`define SBPU_MODIFY_BIT 0
`define SBPU_PAGE_ZERO 12'h000

// Bit of a caching attribute that marks a line L3 cacheable.
`define SBPU_MOCS_L3_BIT 0

// Register byte addresses.
`define SBPU_ADDR_CTRL 4'h0
`define SBPU_ADDR_STATUS 4'h4
`define SBPU_ADDR_GENERAL 4'h8
`define SBPU_ADDR_SURFACE 4'hC
`define SBPU_CTRL_ACCEPT_BIT 0
`define SBPU_CTRL_RESET 1'h1

// Status layout.
`define SBPU_STAT_BUSY_BIT 0
`define SBPU_STAT_FLUSH_BIT 1
`define SBPU_STAT_CNT_LO 8

// AXI responses.
`define SBPU_RESP_OKAY 2'h0
`define SBPU_RESP_SLVERR 2'h2

`endif

// [common/sbpu_pkg.sv]
`default_nettype none

package sbpu_pkg;

  typedef struct packed {
    logic [19:0] base;
    logic [3:0] mocs;
    logic [3:0] sdp_mocs;
    logic force_wt;
  } sbpu_gen_state_t;

  typedef struct packed {
    logic [19:0] base;
    logic [3:0] mocs;
  } sbpu_surf_state_t;

  typedef enum logic [1:0] {
    SBPU_IDLE,
    SBPU_FLUSH,
    SBPU_BODY
  } sbpu_state_t;

endpackage

`default_nettype wire

// [hw/sbpu_base_field.sv]
`timescale 1ns/1ps
`default_nettype none

// Holds one gated pointer group; a load without its enable is dropped.
module sbpu_base_field #(
  parameter int W = 24
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic enable_in,
  input wire logic [W-1:0] data_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] q_reg;
  wire take = load_in & enable_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_reg <= '0;
    end else if (take) begin
      q_reg <= data_in;
    end
  end

  assign q_out = q_reg;

endmodule // sbpu_base_field

`default_nettype wire

// [hw/sbpu_axil_slave.sv]
`timescale 1ns/1ps
`default_nettype none

`include "sbpu_defines.svh"

// Address and data may arrive in either order; the write is done once
// both are held, which costs a cycle but keeps the decode registered.
module sbpu_axil_slave (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [3:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic wr_en_out,
  output logic [3:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_ok_in
);

  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [3:0] awaddr_reg, wstrb_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;

  wire aw_take = awvalid_in & awready_out;
  wire w_take = wvalid_in & wready_out;
  wire ar_take = arvalid_in & arready_out;
  wire do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;

  assign awready_out = ~aw_full_reg & ~bvalid_reg;
  assign wready_out = ~w_full_reg & ~bvalid_reg;
  assign arready_out = ~rvalid_reg;
  assign bvalid_out = bvalid_reg;
  assign bresp_out = bresp_reg;
  assign rvalid_out = rvalid_reg;
  assign rresp_out = rresp_reg;
  assign rdata_out = rdata_reg;
  assign wr_en_out = do_wr;
  assign wr_addr_out = awaddr_reg;
  assign wr_data_out = wdata_reg;
  assign wr_strb_out = wstrb_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SBPU_RESP_OKAY;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= awaddr_in;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        wdata_reg <= wdata_in;
        wstrb_reg <= wstrb_in;
      end
      if (do_wr) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok_in ? `SBPU_RESP_OKAY : `SBPU_RESP_SLVERR;
      end else if (bvalid_reg & bready_in) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `SBPU_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_ok_in ? rd_data_in : 32'h00000000;
      rresp_reg <= rd_ok_in ? `SBPU_RESP_OKAY : `SBPU_RESP_SLVERR;
    end else if (rvalid_reg & rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule // sbpu_axil_slave

`default_nettype wire

// [hw/sbpu_top.sv]
`timescale 1ns/1ps
`default_nettype none

`include "sbpu_defines.svh"

// Function
// - General base is dword 1 bits 31:12, 4K aligned.
// - Dword 1 bits 11:8 cache general indirect state.
// - Dword 1 bits 7:4 cache stateless accesses.
// - Bit 3 selects write-through for L3 stateless.
// - Dword 1 fields change only when bit 0 set.
// - Surface base is dword 2 bits 31:12, 4K aligned.
// - Dword 2 bits 11:8 cache surface state.
// - Dword 2 fields change only when bit 0 set.
// - Recognise header by type, subtype and opcodes.
// - Flush the pipeline whenever the command executes.
module sbpu_top
  import sbpu_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [31:0] CMD_DATA_IN,
  input wire logic CMD_VALID_IN,
  output logic CMD_READY_OUT,
  output logic FLUSH_REQ_OUT,
  input wire logic FLUSH_DONE_IN,
  output logic [31:0] GEN_BASE_ADDR_OUT,
  output logic [31:0] SURF_BASE_ADDR_OUT,
  output var sbpu_gen_state_t GEN_STATE_OUT,
  output var sbpu_surf_state_t SURF_STATE_OUT,
  output logic SDP_WRITE_THRU_OUT,
  input wire logic [3:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [3:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN
);

  sbpu_state_t state_reg, state_next;
  logic [8:0] left_reg, left_next;
  logic [1:0] idx_reg, idx_next;
  logic ours_reg, ours_next;
  logic accept_reg;
  logic [7:0] exec_cnt_reg;
  sbpu_gen_state_t gen_q;
  sbpu_surf_state_t surf_q;

  wire beat = CMD_VALID_IN & CMD_READY_OUT;
  wire [31:0] dw = CMD_DATA_IN;
  wire [7:0] hdr_len = dw[`SBPU_HDR_LEN_HI:`SBPU_HDR_LEN_LO];

  // Reserved header and body bits are never looked at.
  wire hdr_match =
    dw[`SBPU_HDR_TYPE_HI:`SBPU_HDR_TYPE_LO] == `SBPU_HDR_TYPE &&
    dw[`SBPU_HDR_SUB_HI:`SBPU_HDR_SUB_LO] == `SBPU_HDR_SUBTYPE &&
    dw[`SBPU_HDR_OP_HI:`SBPU_HDR_OP_LO] == `SBPU_HDR_OPCODE &&
    dw[`SBPU_HDR_SOP_HI:`SBPU_HDR_SOP_LO] == `SBPU_HDR_SUBOP;

  wire in_body = state_reg == SBPU_BODY;
  wire body_beat = beat & in_body & ours_reg;
  wire gen_load = body_beat & (idx_reg == `SBPU_DW_GENERAL);
  wire surf_load = body_beat & (idx_reg == `SBPU_DW_SURFACE);
  wire modify_en = dw[`SBPU_MODIFY_BIT];

  // Field slices of the current body dword.
  wire [19:0] dw_base = dw[`SBPU_BASE_HI:`SBPU_BASE_LO];
  wire [3:0] dw_mocs = dw[`SBPU_MOCS_HI:`SBPU_MOCS_LO];
  wire [3:0] dw_sdp = dw[`SBPU_SDP_HI:`SBPU_SDP_LO];
  wire dw_wt = dw[`SBPU_FORCE_WT_BIT];

  wire sbpu_gen_state_t gen_d = '{base: dw_base, mocs: dw_mocs,
                                  sdp_mocs: dw_sdp, force_wt: dw_wt};
  wire sbpu_surf_state_t surf_d = '{base: dw_base, mocs: dw_mocs};

  // Pointers move only on the body dword whose enable bit is set.
  sbpu_base_field #(
    .W($bits(sbpu_gen_state_t))
  ) u_gen_field (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .load_in(gen_load),
    .enable_in(modify_en),
    .data_in(gen_d),
    .q_out(gen_q)
  );

  sbpu_base_field #(
    .W($bits(sbpu_surf_state_t))
  ) u_surf_field (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .load_in(surf_load),
    .enable_in(modify_en),
    .data_in(surf_d),
    .q_out(surf_q)
  );

  assign GEN_STATE_OUT = gen_q;
  assign SURF_STATE_OUT = surf_q;
  assign GEN_BASE_ADDR_OUT = {gen_q.base, `SBPU_PAGE_ZERO};
  assign SURF_BASE_ADDR_OUT = {surf_q.base, `SBPU_PAGE_ZERO};

  // Write-through only applies to lines that are L3 cacheable; the
  // select is registered with the general group so it never glitches.
  logic sdp_wt_reg;

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sdp_wt_reg <= 1'b0;
    end else if (gen_load & modify_en) begin
      sdp_wt_reg <= dw_sdp[`SBPU_MOCS_L3_BIT] & dw_wt;
    end
  end

  assign SDP_WRITE_THRU_OUT = sdp_wt_reg;

  // The body is held off until the flush completes, so no later state
  // fetch can see a half-updated pointer set.
  assign FLUSH_REQ_OUT = state_reg == SBPU_FLUSH;
  assign CMD_READY_OUT = (state_reg == SBPU_IDLE & accept_reg) | in_body;

  always_comb begin
    state_next = state_reg;
    left_next = left_reg;
    idx_next = idx_reg;
    ours_next = ours_reg;
    unique case (state_reg)
      SBPU_IDLE: begin
        if (beat) begin
          left_next = {1'b0, hdr_len} + 9'h001;
          idx_next = `SBPU_DW_GENERAL;
          ours_next = hdr_match;
          state_next = hdr_match ? SBPU_FLUSH : SBPU_BODY;
        end
      end
      SBPU_FLUSH: begin
        if (FLUSH_DONE_IN) begin
          state_next = SBPU_BODY;
        end
      end
      SBPU_BODY: begin
        if (beat) begin
          left_next = left_reg - 9'h001;
          if (idx_reg != 2'h3) begin
            idx_next = idx_reg + 2'h1;
          end
          if (left_reg == 9'h001) begin
            state_next = SBPU_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_reg <= SBPU_IDLE;
      left_reg <= 9'h000;
      idx_reg <= 2'h0;
      ours_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      left_reg <= left_next;
      idx_reg <= idx_next;
      ours_reg <= ours_next;
    end
  end

  // Register bus.
  logic wr_en;
  logic [3:0] wr_addr, wr_strb;
  logic [31:0] wr_data;

  wire wr_ctrl = wr_addr == `SBPU_ADDR_CTRL;
  wire wr_ok = wr_ctrl | wr_addr == `SBPU_ADDR_STATUS |
               wr_addr == `SBPU_ADDR_GENERAL |
               wr_addr == `SBPU_ADDR_SURFACE;
  wire ctrl_we = wr_en & wr_ctrl & wr_strb[0];

  wire [31:0] rd_ctrl = {31'h00000000, accept_reg};
  wire [31:0] rd_status = {16'h0000, exec_cnt_reg, 6'h00,
                           FLUSH_REQ_OUT, state_reg != SBPU_IDLE};
  wire [31:0] rd_gen = {gen_q.base, gen_q.mocs, gen_q.sdp_mocs,
                        gen_q.force_wt, 3'h0};
  wire [31:0] rd_surf = {surf_q.base, surf_q.mocs, 8'h00};
  wire [3:0] ra = S_AXI_ARADDR_IN;
  wire rd_ok = ra == `SBPU_ADDR_CTRL | ra == `SBPU_ADDR_STATUS |
               ra == `SBPU_ADDR_GENERAL | ra == `SBPU_ADDR_SURFACE;
  wire [31:0] rd_data =
    ra == `SBPU_ADDR_CTRL ? rd_ctrl :
    ra == `SBPU_ADDR_STATUS ? rd_status :
    ra == `SBPU_ADDR_GENERAL ? rd_gen : rd_surf;

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      accept_reg <= `SBPU_CTRL_RESET;
      exec_cnt_reg <= 8'h00;
    end else begin
      if (ctrl_we) begin
        accept_reg <= wr_data[`SBPU_CTRL_ACCEPT_BIT];
      end
      if (state_reg == SBPU_FLUSH & FLUSH_DONE_IN) begin
        exec_cnt_reg <= exec_cnt_reg + 8'h01;
      end
    end
  end

  sbpu_axil_slave u_axil (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .awaddr_in(S_AXI_AWADDR_IN),
    .awvalid_in(S_AXI_AWVALID_IN),
    .awready_out(S_AXI_AWREADY_OUT),
    .wdata_in(S_AXI_WDATA_IN),
    .wstrb_in(S_AXI_WSTRB_IN),
    .wvalid_in(S_AXI_WVALID_IN),
    .wready_out(S_AXI_WREADY_OUT),
    .bresp_out(S_AXI_BRESP_OUT),
    .bvalid_out(S_AXI_BVALID_OUT),
    .bready_in(S_AXI_BREADY_IN),
    .araddr_in(S_AXI_ARADDR_IN),
    .arvalid_in(S_AXI_ARVALID_IN),
    .arready_out(S_AXI_ARREADY_OUT),
    .rdata_out(S_AXI_RDATA_OUT),
    .rresp_out(S_AXI_RRESP_OUT),
    .rvalid_out(S_AXI_RVALID_OUT),
    .rready_in(S_AXI_RREADY_IN),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(wr_ok),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok)
  );

  // Checks.
  sequence s_hdr_taken;
    beat && state_reg == SBPU_IDLE && hdr_match;
  endsequence

  sequence s_flush_done;
    state_reg == SBPU_FLUSH && FLUSH_DONE_IN;
  endsequence

  a_hdr_to_flush: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    s_hdr_taken |=> FLUSH_REQ_OUT && !CMD_READY_OUT)
    else $error("Matching header did not start a flush.");

  a_flush_then_body: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    s_flush_done |=> state_reg == SBPU_BODY && idx_reg == 2'h1)
    else $error("Flush completion did not open the body.");

  a_flush_blocks_load: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    FLUSH_REQ_OUT |=> $stable(gen_q) && $stable(surf_q))
    else $error("Pointers changed while flushing.");

  a_gen_base_load: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    gen_load && dw[0] |=> GEN_BASE_ADDR_OUT == {$past(dw[31:12]), 12'h000}
      && GEN_STATE_OUT.mocs == $past(dw[11:8]))
    else $error("General base or attribute not taken.");

  a_sdp_attr_load: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    gen_load && dw[0] |=> GEN_STATE_OUT.sdp_mocs == $past(dw[7:4]))
    else $error("Stateless attribute not taken.");

  a_gen_hold: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    gen_load && !dw[0] |=> GEN_STATE_OUT == $past(GEN_STATE_OUT))
    else $error("General fields changed without modify enable.");

  a_surf_load: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    surf_load && dw[0] |=> SURF_BASE_ADDR_OUT[31:12] == $past(dw[31:12])
      && SURF_STATE_OUT.mocs == $past(dw[11:8]))
    else $error("Surface base or attribute not taken.");

  a_surf_hold: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    surf_load && !dw[0] |=> $stable(SURF_STATE_OUT))
    else $error("Surface fields changed without modify enable.");

  a_wt_select: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    gen_load && dw[0] && dw[4] |=> SDP_WRITE_THRU_OUT == $past(dw[3]))
    else $error("Write-through select wrong for L3 stateless.");

  a_surf_only_dw2: assert property (@(posedge MCLK_IN)
    disable iff (SYS_RST_IN)
    !surf_load |=> $stable(SURF_STATE_OUT) &&
      SURF_BASE_ADDR_OUT[11:0] == 12'h000)
    else $error("Surface fields moved without their own dword.");

endmodule // sbpu_top

`default_nettype wire

// [testbench/sbpu_parser_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Stands in for the command parser. Idle data shows the inverse of the
// last word, so a design that samples without valid sees no stale match.
module sbpu_parser_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ready_in,
  input wire logic flush_req_in,
  output logic [31:0] data_out,
  output logic valid_out,
  output logic flush_done_out
);
  int flush_wait = 0;
  int cnt;

  initial begin
    data_out = 32'h0;
    valid_out = 1'b0;
  end

  // Each dword is held until the edge that takes it.
  task automatic send_cmd(input logic [31:0] q[$]);
    @(posedge clk_in);
    foreach (q[i]) begin
      data_out <= q[i];
      valid_out <= 1'b1;
      do @(posedge clk_in); while (ready_in !== 1'b1);
    end
    valid_out <= 1'b0;
    data_out <= ~q[q.size()-1];
  endtask

  // Done is a one-cycle pulse that rises flush_wait+1 cycles after the request.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      flush_done_out <= 1'b0;
    end else if (flush_req_in && !flush_done_out && cnt >= flush_wait) begin
      cnt <= 0;
      flush_done_out <= 1'b1;
    end else begin
      flush_done_out <= 1'b0;
      cnt <= flush_req_in ? cnt + 1 : 0;
    end
  end
endmodule // sbpu_parser_model
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbpu_defines.svh"

module testbench
  import sbpu_pkg::*;
;
  logic clk, rst, cmd_valid, cmd_ready, flush_req, flush_done, sdp_wt;
  logic [31:0] cmd_data, gen_addr, surf_addr, wdata, rdata, e1, e2;
  sbpu_gen_state_t gen_st;
  sbpu_surf_state_t surf_st;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int mismatches, samples_checked, cyc, fl_cnt, ncmd;

  sbpu_top dut_u (.MCLK_IN(clk), .SYS_RST_IN(rst), .CMD_DATA_IN(cmd_data),
    .CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(cmd_ready),
    .FLUSH_REQ_OUT(flush_req), .FLUSH_DONE_IN(flush_done),
    .GEN_BASE_ADDR_OUT(gen_addr), .SURF_BASE_ADDR_OUT(surf_addr),
    .GEN_STATE_OUT(gen_st), .SURF_STATE_OUT(surf_st),
    .SDP_WRITE_THRU_OUT(sdp_wt), .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));

  sbpu_parser_model model_u (.clk_in(clk), .rst_in(rst),
    .ready_in(cmd_ready), .flush_req_in(flush_req), .data_out(cmd_data),
    .valid_out(cmd_valid), .flush_done_out(flush_done));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // A hang counts as a failure and still reaches the closing report.
  always @(posedge clk) begin
    cyc++;
    if (flush_req === 1'b1) fl_cnt++;
    if (cyc == 5000) begin
      mismatches++;
      $display("ERROR %0t: timeout", $time);
      close_out;
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    check(bresp, `SBPU_RESP_OKAY);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    check(rdata, exp);
    check(rresp, `SBPU_RESP_OKAY);
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] hdr(input logic [7:0] sop, len);
    return {3'h3, 2'h0, 3'h1, sop, 8'h00, len};
  endfunction

  task automatic check_ptrs;
    check(gen_addr, {e1[31:12], 12'h000});
    check(gen_st, e1[31:3]);
    check(sdp_wt, e1[4] & e1[3]);
    check(surf_addr, {e2[31:12], 12'h000});
    check(surf_st, e2[31:8]);
  endtask

  task automatic run(input logic [31:0] q[$], input int w, input int fl);
    fl_cnt = 0;
    model_u.flush_wait = w;
    model_u.send_cmd(q);
    repeat (3) @(posedge clk);
    check(fl_cnt, fl);
    check_ptrs;
  endtask

  task automatic t_reset;
    e1 = 32'h0;
    e2 = 32'h0;
    check_ptrs;
    check(cmd_ready, 1'b1);
    rd(`SBPU_ADDR_CTRL, 32'h1);
    rd(`SBPU_ADDR_STATUS, 32'h0);
    $display("test reset done");
  endtask

  // Reserved bits are set on purpose and dwords past 2 carry bit 0 set.
  task automatic t_full;
    logic [31:0] q[$];
    e1 = 32'hABCDE79F;
    e2 = 32'h12345AFF;
    q = {hdr(8'h01, 8'h08), e1, e2};
    repeat (7) q.push_back(32'hFFFFFFFF);
    run(q, 5, 7);
    ncmd++;
    rd(`SBPU_ADDR_GENERAL, {e1[31:3], 3'b000});
    rd(`SBPU_ADDR_SURFACE, {e2[31:8], 8'h00});
    $display("test full done");
  endtask

  task automatic t_hold;
    run({hdr(8'h01, 8'h01), 32'h11111110, 32'h22222220}, 0, 2);
    ncmd++;
    $display("test hold done");
  endtask

  task automatic t_foreign;
    run({hdr(8'h02, 8'h01), 32'h33333001, 32'h44444001}, 0, 0);
    check(cmd_ready, 1'b1);
    $display("test foreign done");
  endtask

  // Every pairing of the L3 bit and the write-through bit, length zero.
  task automatic t_wthru;
    logic [1:0] b;
    for (int i = 0; i < 4; i++) begin
      b = i[1:0];
      e1 = {20'h0F0F0, 4'h3, 3'b010, b[0], b[1], 3'b001};
      run({hdr(8'h01, 8'h00), e1}, 0, 2);
      ncmd++;
    end
    $display("test write-through done");
  endtask

  task automatic t_ctrl;
    wr(`SBPU_ADDR_CTRL, 32'h0);
    @(posedge clk);
    check(cmd_ready, 1'b0);
    wstrb <= 4'hE;
    wr(`SBPU_ADDR_CTRL, 32'h1);
    wstrb <= 4'hF;
    @(posedge clk);
    check(cmd_ready, 1'b0);
    wr(`SBPU_ADDR_GENERAL, 32'h5A5A5A5A);
    rd(`SBPU_ADDR_GENERAL, {e1[31:3], 3'b000});
    wr(`SBPU_ADDR_CTRL, 32'h1);
    @(posedge clk);
    check(cmd_ready, 1'b1);
    rd(`SBPU_ADDR_STATUS, {16'h0, ncmd[7:0], 8'h00});
    $display("test control done");
  endtask

  initial begin
    rst = 1'b1;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {mismatches, samples_checked, cyc, fl_cnt, ncmd} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_full;
    t_hold;
    t_foreign;
    t_wthru;
    t_ctrl;
    close_out;
  end
endmodule // testbench
`default_nettype wire
